/* File: src/fsr_fuse_store.sv */
// Purpose: Fuse area, factory information row and user data row with lock-based access
// Assumes: One clock; requests come from same-clock logic; one request per port per cycle
// Notes:   Fuses and user row held in flip-flops; fuse reload only on reset release
//
// Summary of operation
// - Locked: port may write user data row, but reads return invalid data.
// - Forbidden port reads complete normally with invalid data.
// - Only a full erase command unlocks; it restores fuses and user row to default.
// - CPU and port read fuses; only the port writes them; CPU writes ignored.
// - At end of start-up, fuse values are copied into target registers.
// - Fuse contents are readable from the end of start-up, before software runs.
// - Factory row rejects every write from CPU or port.
// - New fuse values reach the targets only after the next reset reload; the lock fuse acts at once.
// - Three-byte part identifier at factory offsets from zero.
// - Ten-byte unique serial number at factory offsets from 0x03.
// - Factory offset 0x20 holds unsigned temperature gain correction.
// - Factory offset 0x21 holds signed temperature offset correction.
// - Offsets 0x22-0x25 hold signed oscillator errors, 16/20 MHz at 3/5 V.
// - Reset loads watchdog fuse bits 7:4 into the window field.
// - Reset loads watchdog fuse bits 3:0 into the period field.
// - Locked whenever lock fuse differs from the single unlock value.
`include "fsr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module fsr_fuse_store
  import fsr_pkg::*;
#(
  parameter logic [23:0] PART_IDENT = 24'h0a0b0c,      // Arbitrary value
  parameter logic [79:0] SERIAL     = 80'h0123456789abcdef0011,
  parameter logic [7:0]  TEMP_GAIN  = 8'h80,
  parameter logic [7:0]  TEMP_OFFS  = 8'h00,
  parameter logic [31:0] OSC_ERR    = 32'h00000000,
  parameter logic [87:0] FUSE_INIT  = {8'hc5, 8'hff, 8'h00, 8'h00, 8'hff,
                                       8'hc4, 8'hff, 8'hff, 8'h02, 8'h00, 8'h00}
) (
  // Clock and reset
  input  wire logic         i_clk_sys,
  input  wire logic         i_reset_n,
  // CPU read/write request
  input  wire fsr_req_s     i_cpu_req,
  output logic [7:0]        o_cpu_rdata,
  output logic              o_cpu_rvalid,
  // Programming and debug port request
  input  wire fsr_req_s     i_port_req,
  input  wire logic         i_port_full_erase,
  output logic [7:0]        o_port_rdata,
  output logic              o_port_rvalid,
  output logic              o_port_done,
  // Status and loaded targets
  output logic              o_locked,
  output logic              o_config_ready,
  output fsr_wd_ctrl_s      o_watchdog_control_a,
  output logic [7:0]        o_brownout_cfg,
  output logic [7:0]        o_osc_cfg,
  output logic [7:0]        o_sys_cfg_a,
  output logic [7:0]        o_startup_cfg,
  output logic [7:0]        o_app_end,
  output logic [7:0]        o_boot_end
);

  localparam int NF = `FSR_FUSE_COUNT;
  localparam int NU = `FSR_USER_ROW_BYTES;

  typedef struct packed {
    fsr_state_e       st;
    logic [NF*8-1:0]  fuse;
    logic [NU*8-1:0]  user;
    logic             nvm_init;
    logic [7:0]       cpu_rdata;
    logic             cpu_rvalid;
    logic [7:0]       port_rdata;
    logic             port_rvalid;
    logic             port_done;
    logic             locked;
    logic             ready;
    fsr_wd_ctrl_s     wd;
    logic [7:0]       bod;
    logic [7:0]       osc;
    logic [7:0]       sys_a;
    logic [7:0]       sut;
    logic [7:0]       app_end;
    logic [7:0]       boot_end;
  } fsr_state_s;

  fsr_state_s r_q;
  fsr_state_s r_d;

  function automatic logic [7:0] fuse_byte(input logic [NF*8-1:0] f, input logic [5:0] a);
    fuse_byte = `FSR_INVALID_BYTE;
    if (a < 6'(NF)) begin
      fuse_byte = f[a*8 +: 8];
    end
  endfunction

  function automatic logic [7:0] sig_byte(input logic [5:0] a);
    sig_byte = `FSR_INVALID_BYTE;
    if (a < `FSR_SIG_SERIAL0) begin
      sig_byte = PART_IDENT[(2 - a) * 8 +: 8];
    end else if (a <= `FSR_SIG_SERIAL_LAST) begin
      sig_byte = SERIAL[(a - `FSR_SIG_SERIAL0) * 8 +: 8];
    end else if (a == `FSR_SIG_TEMP_GAIN) begin
      sig_byte = TEMP_GAIN;
    end else if (a == `FSR_SIG_TEMP_OFFSET) begin
      sig_byte = TEMP_OFFS;
    end else if (a >= `FSR_SIG_RC16M_3V && a <= `FSR_SIG_LAST) begin
      sig_byte = OSC_ERR[(3 - (a - `FSR_SIG_RC16M_3V)) * 8 +: 8];
    end
  endfunction

  function automatic logic [7:0] user_byte(input logic [NU*8-1:0] u, input logic [5:0] a);
    user_byte = `FSR_INVALID_BYTE;
    if (a < 6'(NU)) begin
      user_byte = u[a*8 +: 8];
    end
  endfunction

  // Read decode shared by CPU and port
  function automatic logic [7:0] read_byte(input fsr_state_s s, input fsr_req_s q);
    read_byte = `FSR_INVALID_BYTE;
    unique case (q.space)
      FSR_SPACE_FUSE: begin
        read_byte = fuse_byte(s.fuse, q.addr);
      end
      FSR_SPACE_SIG: begin
        read_byte = sig_byte(q.addr);
      end
      FSR_SPACE_USER: begin
        read_byte = user_byte(s.user, q.addr);
      end
      FSR_SPACE_EEPROM: begin
        // Data memory lives outside this block
        read_byte = `FSR_INVALID_BYTE;
      end
    endcase
  endfunction

  // User row write inside the row
  function automatic logic user_write_ok(input fsr_req_s q);
    user_write_ok = 1'b0;
    if (q.valid && q.write) begin
      if (q.space == FSR_SPACE_USER && q.addr < 6'(NU)) begin
        user_write_ok = 1'b1;
      end
    end
  endfunction

  // Fuse write allowed from the port
  function automatic logic fuse_write_ok(input fsr_req_s q, input logic locked);
    fuse_write_ok = 1'b0;
    if (!locked && q.valid && q.write) begin
      if (q.space == FSR_SPACE_FUSE && q.addr < 6'(NF)) begin
        fuse_write_ok = 1'b1;
      end
    end
  endfunction

  // Lock state from the lock fuse
  function automatic logic lock_decode(input logic [NF*8-1:0] f);
    lock_decode = (f[`FSR_FUSE_DEBUG_LOCK*8 +: 8] != `FSR_UNLOCK_VALUE);
  endfunction

  // Watchdog control fields from the watchdog fuse
  function automatic fsr_wd_ctrl_s wd_load(input logic [NF*8-1:0] f);
    logic [7:0] b;
    b = f[`FSR_FUSE_WATCHDOG*8 +: 8];
    wd_load.window = b[`FSR_WD_WINDOW_HI:`FSR_WD_WINDOW_LO];
    wd_load.period = b[`FSR_WD_PERIOD_HI:`FSR_WD_PERIOD_LO];
  endfunction

  // Whole fuse byte for a target
  function automatic logic [7:0] fuse_copy(input logic [NF*8-1:0] f, input logic [3:0] idx);
    fuse_copy = f[idx*8 +: 8];
  endfunction

  always_comb begin
    r_d = r_q;
    r_d.cpu_rvalid  = 1'b0;
    r_d.port_rvalid = 1'b0;
    r_d.port_done   = 1'b0;
    r_d.locked = lock_decode(r_q.fuse);

    unique case (r_q.st)
      FSR_ST_BOOT: begin
        // contents loaded with the default image unless already initialised
        // Unknown marker after power-up counts as blank
        if (r_q.nvm_init) begin
          r_d.nvm_init = 1'b1;
        end else begin
          r_d.fuse     = FUSE_INIT;
          r_d.user     = {NU{`FSR_ERASED_BYTE}};
          r_d.nvm_init = 1'b1;
        end
        r_d.st = FSR_ST_LOAD;
      end
      FSR_ST_LOAD: begin
        r_d.wd       = wd_load(r_q.fuse);
        r_d.bod      = fuse_copy(r_q.fuse, `FSR_FUSE_BROWNOUT);
        r_d.osc      = fuse_copy(r_q.fuse, `FSR_FUSE_OSC);
        r_d.sys_a    = fuse_copy(r_q.fuse, `FSR_FUSE_SYS_A);
        r_d.sut      = fuse_copy(r_q.fuse, `FSR_FUSE_STARTUP);
        r_d.app_end  = fuse_copy(r_q.fuse, `FSR_FUSE_APP_END);
        r_d.boot_end = fuse_copy(r_q.fuse, `FSR_FUSE_BOOT_END);
        r_d.ready    = 1'b1;
        r_d.st       = FSR_ST_RUN;
      end
      FSR_ST_RUN: begin
        // CPU side
        if (i_cpu_req.valid && !i_cpu_req.write) begin
          r_d.cpu_rvalid = 1'b1;
          r_d.cpu_rdata  = read_byte(r_q, i_cpu_req);
        end
        if (user_write_ok(i_cpu_req)) begin
          r_d.user[i_cpu_req.addr*8 +: 8] = i_cpu_req.wdata;
        end
        // Port side
        if (i_port_full_erase) begin
          r_d.fuse      = FUSE_INIT;
          r_d.user      = {NU{`FSR_ERASED_BYTE}};
          r_d.port_done = 1'b1;
        end else if (i_port_req.valid) begin
          r_d.port_done = 1'b1;
          if (!i_port_req.write) begin
            r_d.port_rvalid = 1'b1;
            if (r_q.locked) begin
              r_d.port_rdata = `FSR_INVALID_BYTE;
            end else begin
              r_d.port_rdata = read_byte(r_q, i_port_req);
            end
          end else begin
            if (user_write_ok(i_port_req)) begin
              r_d.user[i_port_req.addr*8 +: 8] = i_port_req.wdata;
            end
            if (fuse_write_ok(i_port_req, r_q.locked)) begin
              r_d.fuse[i_port_req.addr*8 +: 8] = i_port_req.wdata;
            end
          end
        end
      end
      default: r_d.st = FSR_ST_BOOT;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      // Keep nonvolatile contents; restart the reload
      r_q.st          <= FSR_ST_BOOT;
      r_q.cpu_rvalid  <= 1'b0;
      r_q.port_rvalid <= 1'b0;
      r_q.port_done   <= 1'b0;
      r_q.ready       <= 1'b0;
      r_q.cpu_rdata   <= `FSR_RDATA_RESET;
      r_q.port_rdata  <= `FSR_RDATA_RESET;
      r_q.locked      <= 1'b1;
      r_q.fuse        <= r_d.fuse;
      r_q.user        <= r_d.user;
      r_q.nvm_init    <= r_d.nvm_init;
      r_q.wd          <= r_q.wd;
      r_q.bod         <= r_q.bod;
      r_q.osc         <= r_q.osc;
      r_q.sys_a       <= r_q.sys_a;
      r_q.sut         <= r_q.sut;
      r_q.app_end     <= r_q.app_end;
      r_q.boot_end    <= r_q.boot_end;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_cpu_rdata          = r_q.cpu_rdata;
  assign o_cpu_rvalid         = r_q.cpu_rvalid;
  assign o_port_rdata         = r_q.port_rdata;
  assign o_port_rvalid        = r_q.port_rvalid;
  assign o_port_done          = r_q.port_done;
  assign o_locked             = r_q.locked;
  assign o_config_ready       = r_q.ready;
  assign o_watchdog_control_a = r_q.wd;
  assign o_brownout_cfg       = r_q.bod;
  assign o_osc_cfg            = r_q.osc;
  assign o_sys_cfg_a          = r_q.sys_a;
  assign o_startup_cfg        = r_q.sut;
  assign o_app_end            = r_q.app_end;
  assign o_boot_end           = r_q.boot_end;

endmodule // fsr_fuse_store

`default_nettype wire

/* File: src/fsr_map.svh */
// Purpose: Offsets, field positions and reset values of the fuse and factory row store
// Assumes: Byte-wide rows addressed by byte offset
// Notes:   Definitions only
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// Factory information row offsets
`define FSR_SIG_PART_IDENT0   6'h00
`define FSR_SIG_SERIAL0       6'h03
`define FSR_SIG_SERIAL_LAST   6'h0c
`define FSR_SIG_TEMP_GAIN     6'h20
`define FSR_SIG_TEMP_OFFSET   6'h21
`define FSR_SIG_RC16M_3V      6'h22
`define FSR_SIG_RC16M_5V      6'h23
`define FSR_SIG_RC20M_3V      6'h24
`define FSR_SIG_RC20M_5V      6'h25
`define FSR_SIG_LAST          6'h25

// Fuse area offsets
`define FSR_FUSE_WATCHDOG     4'h0
`define FSR_FUSE_BROWNOUT     4'h1
`define FSR_FUSE_OSC          4'h2
`define FSR_FUSE_SYS_A        4'h5
`define FSR_FUSE_STARTUP      4'h6
`define FSR_FUSE_APP_END      4'h7
`define FSR_FUSE_BOOT_END     4'h8
`define FSR_FUSE_DEBUG_LOCK   4'ha
`define FSR_FUSE_COUNT        11

// Fuse field positions
`define FSR_WD_WINDOW_HI      7
`define FSR_WD_WINDOW_LO      4
`define FSR_WD_PERIOD_HI      3
`define FSR_WD_PERIOD_LO      0

// Values
`define FSR_UNLOCK_VALUE      8'hc5
`define FSR_ERASED_BYTE       8'hff
`define FSR_INVALID_BYTE      8'h00
`define FSR_RDATA_RESET       8'h00
`define FSR_USER_ROW_BYTES    32

`endif

/* File: src/fsr_pkg.sv */
// Purpose: Types of the fuse and factory row store
// Assumes: Constants live in fsr_map.svh
// Notes:   None
package fsr_pkg;

  typedef enum logic [1:0] {
    FSR_SPACE_FUSE,
    FSR_SPACE_SIG,
    FSR_SPACE_USER,
    FSR_SPACE_EEPROM
  } fsr_space_e;

  typedef enum logic [1:0] {
    FSR_ST_BOOT,
    FSR_ST_LOAD,
    FSR_ST_RUN
  } fsr_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    fsr_space_e space;
    logic [5:0] addr;
    logic [7:0] wdata;
  } fsr_req_s;

  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fsr_wd_ctrl_s;

endpackage

/* File: tb/fsr_props.sv */
// Purpose: Port checks of the fuse store
// Assumes: Bound to fsr_fuse_store, default fuse image
// Notes:   One clock domain
`timescale 1ns/1ps
`default_nettype none

module fsr_props
  import fsr_pkg::*;
#(
  parameter logic [23:0] PART_IDENT = 24'h000000
) (
  // Clock and reset
  input wire logic         i_clk_sys,
  input wire logic         i_reset_n,
  // Requests
  input wire fsr_req_s     i_cpu_req,
  input wire fsr_req_s     i_port_req,
  input wire logic         i_port_full_erase,
  // Answers and status
  input wire logic [7:0]   o_cpu_rdata,
  input wire logic         o_cpu_rvalid,
  input wire logic [7:0]   o_port_rdata,
  input wire logic         o_port_rvalid,
  input wire logic         o_port_done,
  input wire logic         o_locked,
  input wire logic         o_config_ready,
  input wire fsr_wd_ctrl_s o_watchdog_control_a
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);

  logic cr, pr, pw, pe, ps;
  assign cr = i_cpu_req.valid && !i_cpu_req.write && o_config_ready;
  assign pe = i_port_full_erase && o_config_ready;
  assign pr = i_port_req.valid && !i_port_req.write && o_config_ready && !i_port_full_erase;
  assign pw = i_port_req.valid && i_port_req.write && o_config_ready && !i_port_full_erase;
  assign ps = i_port_req.space == FSR_SPACE_SIG && i_port_req.addr == 6'h00;

  chk_cpu_rd_lat: assert property (cr |=> o_cpu_rvalid)
    else $error("cpu read not answered");
  chk_port_done: assert property (pr || pw || pe |=> o_port_done)
    else $error("port request not completed");
  chk_wr_no_data: assert property (pw |=> o_port_done && !o_port_rvalid)
    else $error("port write returned data");
  chk_lock_rd_zero: assert property (pr && o_locked |=> o_port_rvalid && o_port_rdata == 8'h00)
    else $error("locked read returned data");
  chk_ident_port: assert property (pr && !o_locked && ps |=> o_port_rdata == PART_IDENT[23:16])
    else $error("port ident byte wrong");
  chk_ident_cpu: assert property (cr && i_cpu_req.space == FSR_SPACE_SIG
    && i_cpu_req.addr == 6'h00 |=> o_cpu_rdata == PART_IDENT[23:16])
    else $error("cpu ident byte wrong");
  chk_wd_hold: assert property (o_config_ready && $past(o_config_ready)
    |-> $stable(o_watchdog_control_a))
    else $error("watchdog target changed without reset");
  chk_ready_load: assert property ($rose(i_reset_n) |-> !o_config_ready ##[1:4] o_config_ready)
    else $error("targets not loaded after reset");
  chk_erase_unlock: assert property (pe |-> ##[1:3] !o_locked)
    else $error("erase did not unlock");

  cov_erase: cover property (pe);
  cov_locked_rd: cover property (pr && o_locked);
  cov_fuse_wr: cover property (pw && i_port_req.space == FSR_SPACE_FUSE);
endmodule // fsr_props

bind fsr_fuse_store fsr_props #(.PART_IDENT(PART_IDENT)) u_fsr_props (.*);

`default_nettype wire

/* File: tb/fsr_prog_model.sv */
// Purpose: External programmer on the programming and debug port
// Assumes: Requests issued only while the store is ready
// Notes:   Released request clears valid, keeps space, inverts write, address and data
`timescale 1ns/1ps
`default_nettype none

module fsr_prog_model
  import fsr_pkg::*;
(
  // Clock and answer
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  // Request to store
  output var fsr_req_s    o_req,
  output var logic        o_erase
);
  initial begin
    o_req = '0;
    o_erase = 1'b0;
  end

  task automatic op(input logic w, input fsr_space_e s, input logic [5:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    logic [7:0] m;
    m = 8'h00;
    if (s == FSR_SPACE_FUSE) begin
      case (a)
        6'h02: m = 8'h7c;
        6'h03, 6'h04, 6'h09: m = 8'hff;
        6'h05: m = 8'h32;
        6'h06: m = 8'hf8;
        default: m = 8'h00;
      endcase
    end
    @(posedge i_clk_sys);
    o_req <= '{1'b1, w, s, a, d | m};
    @(posedge i_clk_sys);
    o_req <= '{1'b0, ~w, s, ~a, ~(d | m)};
    @(posedge i_clk_sys);
    q = i_rdata;
  endtask

  task automatic erase();
    @(posedge i_clk_sys);
    o_erase <= 1'b1;
    @(posedge i_clk_sys);
    o_erase <= 1'b0;
  endtask
endmodule // fsr_prog_model

`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the fuse store
// Assumes: Default fuse image, unlocked
// Notes:   Fixed-seed random data
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import fsr_pkg::*;
  localparam logic [23:0] PART_IDENT = 24'h5a6b7c; // Arbitrary value
  localparam logic [79:0] SERIAL = 80'h102132435465768798a9;
  localparam logic [31:0] OSC_ERR = 32'h04fc08f8;
  logic i_clk_sys, i_reset_n, erase, locked, ready;
  fsr_req_s cpu_req, port_req;
  fsr_wd_ctrl_s wd;
  logic [7:0] cpu_rdata, port_rdata, osc, sys_a, bod, sut, app_end, boot_end;
  int failures, checks_done, cycles;
  logic [31:0] seed = 32'heae0d823;

  fsr_fuse_store #(.PART_IDENT(PART_IDENT), .SERIAL(SERIAL), .TEMP_GAIN(8'h9d),
    .TEMP_OFFS(8'hf3), .OSC_ERR(OSC_ERR)) u_fsr_fuse_store (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_cpu_req(cpu_req),
    .o_cpu_rdata(cpu_rdata), .o_cpu_rvalid(), .i_port_req(port_req),
    .i_port_full_erase(erase), .o_port_rdata(port_rdata), .o_port_rvalid(),
    .o_port_done(), .o_locked(locked), .o_config_ready(ready),
    .o_watchdog_control_a(wd), .o_brownout_cfg(bod), .o_osc_cfg(osc), .o_sys_cfg_a(sys_a),
    .o_startup_cfg(sut), .o_app_end(app_end), .o_boot_end(boot_end));
  fsr_prog_model u_fsr_prog_model (.i_clk_sys(i_clk_sys), .i_rdata(port_rdata),
    .o_req(port_req), .o_erase(erase));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  function automatic logic [7:0] exp_sig(input int a);
    if (a < 3) return PART_IDENT[8*(2-a) +: 8];
    if (a < 13) return SERIAL[8*(a-3) +: 8];
    if (a == 32) return 8'h9d;
    if (a == 33) return 8'hf3;
    return OSC_ERR[8*(37-a) +: 8];
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cpu_op(input logic w, input fsr_space_e s, input logic [5:0] a,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge i_clk_sys);
    cpu_req <= '{1'b1, w, s, a, d};
    @(posedge i_clk_sys);
    cpu_req <= '{1'b0, ~w, s, ~a, ~d};
    @(posedge i_clk_sys);
    q = cpu_rdata;
  endtask

  task automatic do_reset();
    @(posedge i_clk_sys);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_reset_n <= 1'b1;
    for (int k = 0; k < 20 && ready !== 1'b1; k++) @(posedge i_clk_sys);
  endtask

  task automatic end_of_test();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    logic [7:0] q, r, u;
    i_reset_n = 1'b0;
    cpu_req = '0;
    do_reset();
    chk(osc, 8'h02);
    chk(sys_a, 8'hc4);
    chk(bod, 8'h00);
    chk(sut, 8'hff);
    chk(app_end, 8'h00);
    chk(boot_end, 8'h00);
    chk({7'h0, locked}, 8'h00);
    cpu_op(1'b0, FSR_SPACE_FUSE, 6'h05, 8'h00, q);
    chk(q, 8'hc4);
    r = rnd();
    cpu_op(1'b1, FSR_SPACE_USER, 6'h01, r, q);
    u_fsr_prog_model.op(1'b0, FSR_SPACE_USER, 6'h01, 8'h00, q);
    chk(q, r);
    cpu_op(1'b0, FSR_SPACE_EEPROM, 6'h00, 8'h00, q);
    chk(q, 8'h00);
    for (int a = 0; a < 38; a++) begin
      if (a > 12 && a < 32) continue;
      u_fsr_prog_model.op(1'b1, FSR_SPACE_SIG, 6'(a), rnd(), q);
      u_fsr_prog_model.op(1'b0, FSR_SPACE_SIG, 6'(a), 8'h00, q);
      chk(q, exp_sig(a));
      cpu_op(1'b1, FSR_SPACE_SIG, 6'(a), rnd(), q);
      cpu_op(1'b0, FSR_SPACE_SIG, 6'(a), 8'h00, q);
      chk(q, exp_sig(a));
    end
    r = rnd() | 8'h11;
    u_fsr_prog_model.op(1'b1, FSR_SPACE_FUSE, 6'h00, r, q);
    cpu_op(1'b1, FSR_SPACE_FUSE, 6'h00, ~r, q);
    cpu_op(1'b0, FSR_SPACE_FUSE, 6'h00, 8'h00, q);
    chk(q, r);
    chk(wd, 8'h00);
    do_reset();
    chk(wd, r);
    u_fsr_prog_model.op(1'b1, FSR_SPACE_FUSE, 6'h0a, 8'h3a, q);
    repeat (2) @(posedge i_clk_sys);
    chk({7'h0, locked}, 8'h01);
    u_fsr_prog_model.op(1'b0, FSR_SPACE_FUSE, 6'h05, 8'h00, q);
    chk(q, 8'h00);
    u_fsr_prog_model.op(1'b1, FSR_SPACE_FUSE, 6'h00, ~r, q);
    cpu_op(1'b0, FSR_SPACE_FUSE, 6'h00, 8'h00, q);
    chk(q, r);
    u = (rnd() | 8'h80) & 8'hfe;
    u_fsr_prog_model.op(1'b1, FSR_SPACE_USER, 6'h1f, u, q);
    u_fsr_prog_model.op(1'b0, FSR_SPACE_USER, 6'h1f, 8'h00, q);
    chk(q, 8'h00);
    cpu_op(1'b0, FSR_SPACE_USER, 6'h1f, 8'h00, q);
    chk(q, u);
    u_fsr_prog_model.erase();
    repeat (3) @(posedge i_clk_sys);
    chk({7'h0, locked}, 8'h00);
    cpu_op(1'b0, FSR_SPACE_USER, 6'h1f, 8'h00, q);
    chk(q, 8'hff);
    cpu_op(1'b0, FSR_SPACE_FUSE, 6'h00, 8'h00, q);
    chk(q, 8'h00);
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
